// file: dcd_ctrl_model.sv
// memory controller model that drives the command pins of the decoder
`timescale 1ns/10ps
module dcd_ctrl_model (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic issue_i,
    input wire dcd_pkg::dcd_pins_t cmd_i,
    output dcd_pkg::dcd_pins_t pins_o
);
    // ****************************************
    // pin driver
    // ****************************************
    logic cke_q;
    logic [31:0] junk_q;
    // pins change only just after an edge and hold for the whole cycle
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            // block reset stands in for the reset pin, held inactive afterwards
            cke_q <= 1'b1;
            junk_q <= 32'h5A3C96E1;
            pins_o <= {1'b1, 1'b1, 20'h00000};
        end else begin
            junk_q <= {junk_q[30:0], ~(junk_q[31] ^ junk_q[21])};
            if (issue_i) begin
                cke_q <= cmd_i.cke;
                pins_o <= cmd_i;
            end else begin
                // deselect: other lines toggle so stale values never look valid
                pins_o <= {cke_q, 1'b1, junk_q[19:0]};
            end
        end
    end
endmodule

// file: dcd_odt_win.sv
// odt transition window tracker for power-down entry and exit
`timescale 1ns/10ps
module dcd_odt_win #(
    parameter int ENTRY_CYC = 5,
    parameter int EXIT_CYC = 14
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic entry_i,
    input wire logic exit_i,
    output logic win_o
);
    logic [dcd_pkg::WIN_W-1:0] cnt_q, cnt_d, load;
    logic win_d;

    // ****************************************
    // window counter
    // ****************************************
    // a new period extends, never shortens, so overlapping periods merge into one
    always_comb begin
        load = '0;
        if (exit_i) begin
            load = dcd_pkg::WIN_W'(EXIT_CYC); // RULE2
        end else if (entry_i) begin
            load = dcd_pkg::WIN_W'(ENTRY_CYC); // RULE1
        end
        cnt_d = cnt_q;
        if (load > cnt_q) begin
            cnt_d = load; // RULE1
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
        win_d = (cnt_d != '0);
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
            win_o <= 1'b0;
        end else if (clk_en_i) begin
            cnt_q <= cnt_d;
            win_o <= win_d;
        end
    end
endmodule

// file: dcd_pkg.sv
// constants, types and encodings shared by the command decoder files
package dcd_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int ADDR_W = 14;
    localparam int BANK_W = 3;
    localparam int NUM_BANKS = 8;
    localparam int WIN_W = 8;
    // ****************************************
    // address bit roles
    // ****************************************
    localparam int A_AP = 10;
    localparam int A_BC = 12;
    localparam int MR0_DLL_PD = 12;
    localparam int MR0_BL_LSB = 0;
    localparam logic [BANK_W-1:0] MR0_SEL = 3'h0;
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;
    localparam logic [ADDR_W-1:0] MR0_RST = 14'h0000;
    // ****************************************
    // timing defaults in clock cycles
    // ****************************************
    localparam int WL_DEF = 5;
    localparam int CPDED_DEF = 1;
    localparam int XPDLL_DEF = 10;
    localparam logic [2:0] BURST8_CYC = 3'h4;
    localparam logic [2:0] BURST4_CYC = 3'h2;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {
        DCD_CMD_DES  = 4'h0,
        DCD_CMD_NOP  = 4'h1,
        DCD_CMD_MRS  = 4'h2,
        DCD_CMD_REF  = 4'h3,
        DCD_CMD_SRE  = 4'h4,
        DCD_CMD_SRX  = 4'h5,
        DCD_CMD_PRE  = 4'h6,
        DCD_CMD_PREA = 4'h7,
        DCD_CMD_ACT  = 4'h8,
        DCD_CMD_WR   = 4'h9,
        DCD_CMD_RD   = 4'hA,
        DCD_CMD_PDE  = 4'hB,
        DCD_CMD_PDX  = 4'hC,
        DCD_CMD_ZQCL = 4'hD,
        DCD_CMD_ZQCS = 4'hE,
        DCD_CMD_RSVD = 4'hF
    } dcd_cmd_t;
    typedef enum logic [3:0] {
        DCD_ST_IDLE   = 4'h1,
        DCD_ST_ACTIVE = 4'h2,
        DCD_ST_PD     = 4'h4,
        DCD_ST_SR     = 4'h8
    } dcd_state_t;
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BANK_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
    } dcd_pins_t;
    typedef struct packed {
        dcd_cmd_t cmd;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic auto_pre;
        logic burst8;
    } dcd_req_t;
endpackage

// file: dcd_top.sv
// command decoder and state tracker for a ddr3l sdram die
//
// Function
// [RULE1] short power-down: odt response uncertain from entry period start to exit period end
// [RULE2] short idle: odt response uncertain from exit period start to next entry end
// [RULE3] commands come only from cs, ras, cas, we and cke at the clock edge
// [RULE4] controller holds reset high and uses it only as asynchronous reset; the code samples the active-high sys_rst_i synchronously on the clock edge
// [RULE5] all control low with cke high: mode register set, bank selects register
// [RULE6] write decode; in on-the-fly mode a12 picks chop-4 or burst-8
// [RULE7] read decode; a12 picks burst length, column from a0-a9 and a11
// [RULE8] a10 means auto precharge, all banks, or long zq calibration per command
// [RULE9] bank address picks bank; activate opens row; precharge closes one bank
// [RULE10] odt never steers state; termination is off during self refresh
// [RULE11] raising cke with nop or deselect leaves self refresh
// [RULE12] controller waits 512 cycles after self refresh before any write
// [RULE13] bursts run to completion; fixed or on-the-fly length set by mode register
// [RULE14] no refresh is performed while powered down
// [RULE15] nop never aborts an operation in progress
// [RULE16] cs high is deselect, same as nop, other lines ignored
// [RULE17] controller sends only nop or deselect when cke changes for power-down
// [RULE18] controller enters self refresh only with all banks idle
// [RULE19] undefined pin combinations are reserved and get no defined response
`timescale 1ns/10ps
module dcd_top #(
    parameter int WL = dcd_pkg::WL_DEF,
    parameter int CPDED_CYC = dcd_pkg::CPDED_DEF,
    parameter int XPDLL_CYC = dcd_pkg::XPDLL_DEF
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire dcd_pkg::dcd_pins_t pins_i,
    input wire logic odt_i,
    output dcd_pkg::dcd_req_t req_o,
    output logic req_vld_o,
    output dcd_pkg::dcd_state_t state_o,
    output logic [dcd_pkg::NUM_BANKS-1:0] bank_open_o,
    output logic burst_busy_o,
    output logic refresh_o,
    output logic zq_long_o,
    output logic odt_en_o,
    output logic odt_uncertain_o
);
    // ****************************************
    // declarations
    // ****************************************
    dcd_pkg::dcd_state_t state_q, state_d;
    dcd_pkg::dcd_cmd_t cmd;
    dcd_pkg::dcd_req_t req_d;
    logic cke_prev_q;
    logic [dcd_pkg::ADDR_W-1:0] mr0_q, mr0_d;
    logic [dcd_pkg::NUM_BANKS-1:0] open_q, open_d;
    logic [2:0] bcnt_q, bcnt_d;
    logic vld_d, ref_d, zql_d, odt_d, busy_d;
    logic quiet, burst8, col_cmd, frozen, pd_entry, pd_exit;

    // ****************************************
    // command decode
    // ****************************************
    // odt is not an input to this decode at all
    assign quiet = pins_i.cs_n || ({pins_i.ras_n, pins_i.cas_n, pins_i.we_n} == 3'b111); // RULE16 RULE15
    always_comb begin
        cmd = dcd_pkg::DCD_CMD_RSVD; // RULE19
        if (state_q == dcd_pkg::DCD_ST_SR) begin
            cmd = (pins_i.cke && quiet) ? dcd_pkg::DCD_CMD_SRX : dcd_pkg::DCD_CMD_DES; // RULE11
        end else if (state_q == dcd_pkg::DCD_ST_PD) begin
            cmd = (pins_i.cke && quiet) ? dcd_pkg::DCD_CMD_PDX : dcd_pkg::DCD_CMD_DES;
        end else if (!cke_prev_q) begin
            cmd = dcd_pkg::DCD_CMD_DES;
        end else if (!pins_i.cke) begin
            if (quiet) begin
                cmd = dcd_pkg::DCD_CMD_PDE;
            end else if (!pins_i.cs_n && {pins_i.ras_n, pins_i.cas_n, pins_i.we_n} == 3'b001 && open_q == '0) begin
                cmd = dcd_pkg::DCD_CMD_SRE;
            end
        end else if (pins_i.cs_n) begin
            cmd = dcd_pkg::DCD_CMD_DES; // RULE16
        end else begin
            unique case ({pins_i.ras_n, pins_i.cas_n, pins_i.we_n}) // RULE3
                3'b000: cmd = dcd_pkg::DCD_CMD_MRS; // RULE5
                3'b001: cmd = dcd_pkg::DCD_CMD_REF;
                3'b010: cmd = pins_i.addr[dcd_pkg::A_AP] ? dcd_pkg::DCD_CMD_PREA : dcd_pkg::DCD_CMD_PRE; // RULE8
                3'b011: cmd = dcd_pkg::DCD_CMD_ACT; // RULE9
                3'b100: cmd = dcd_pkg::DCD_CMD_WR; // RULE6
                3'b101: cmd = dcd_pkg::DCD_CMD_RD; // RULE7
                3'b110: cmd = pins_i.addr[dcd_pkg::A_AP] ? dcd_pkg::DCD_CMD_ZQCL : dcd_pkg::DCD_CMD_ZQCS; // RULE8
                3'b111: cmd = dcd_pkg::DCD_CMD_NOP;
            endcase
        end
    end

    // burst length: fixed from the mode register, or per command in on-the-fly mode
    always_comb begin
        burst8 = (mr0_q[dcd_pkg::MR0_BL_LSB+:2] != dcd_pkg::BL_FIXED4); // RULE13
        if (mr0_q[dcd_pkg::MR0_BL_LSB+:2] == dcd_pkg::BL_OTF) begin
            burst8 = pins_i.addr[dcd_pkg::A_BC]; // RULE6 RULE7
        end
    end
    assign col_cmd = (cmd == dcd_pkg::DCD_CMD_WR) || (cmd == dcd_pkg::DCD_CMD_RD);

    // ****************************************
    // state, banks and mode register
    // ****************************************
    always_comb begin
        state_d = state_q;
        open_d = open_q;
        mr0_d = mr0_q;
        unique case (cmd)
            dcd_pkg::DCD_CMD_MRS: begin
                if (pins_i.ba == dcd_pkg::MR0_SEL) begin
                    mr0_d = pins_i.addr; // RULE5
                end
            end
            dcd_pkg::DCD_CMD_ACT: open_d[pins_i.ba] = 1'b1; // RULE9
            dcd_pkg::DCD_CMD_PRE: open_d[pins_i.ba] = 1'b0; // RULE9
            dcd_pkg::DCD_CMD_PREA: open_d = '0; // RULE8
            dcd_pkg::DCD_CMD_WR, dcd_pkg::DCD_CMD_RD: begin
                if (pins_i.addr[dcd_pkg::A_AP]) begin
                    open_d[pins_i.ba] = 1'b0; // RULE8
                end
            end
            dcd_pkg::DCD_CMD_SRE: state_d = dcd_pkg::DCD_ST_SR; // RULE18
            dcd_pkg::DCD_CMD_SRX: state_d = dcd_pkg::DCD_ST_IDLE; // RULE11
            dcd_pkg::DCD_CMD_PDE: state_d = dcd_pkg::DCD_ST_PD;
            // leaving power-down falls back to idle or active from the bank map below
            dcd_pkg::DCD_CMD_PDX: state_d = dcd_pkg::DCD_ST_IDLE;
            default: ;
        endcase
        if (state_d != dcd_pkg::DCD_ST_PD && state_d != dcd_pkg::DCD_ST_SR) begin
            state_d = (open_d == '0) ? dcd_pkg::DCD_ST_IDLE : dcd_pkg::DCD_ST_ACTIVE;
        end
    end

    // ****************************************
    // burst tracking and outputs
    // ****************************************
    // a burst in flight is never cut short; a second column command meanwhile is still reported but does not reload the count
    always_comb begin
        bcnt_d = bcnt_q;
        if (bcnt_q != '0) begin
            bcnt_d = bcnt_q - 1'b1; // RULE13 RULE15
        end else if (col_cmd) begin
            bcnt_d = burst8 ? dcd_pkg::BURST8_CYC : dcd_pkg::BURST4_CYC; // RULE13
        end
        busy_d = (bcnt_d != '0);
        req_d.cmd = cmd;
        req_d.bank = pins_i.ba; // RULE9
        req_d.addr = pins_i.addr; // RULE7
        req_d.auto_pre = col_cmd && pins_i.addr[dcd_pkg::A_AP]; // RULE8
        req_d.burst8 = col_cmd && burst8;
        vld_d = (cmd != dcd_pkg::DCD_CMD_DES) && (cmd != dcd_pkg::DCD_CMD_RSVD);
        ref_d = (cmd == dcd_pkg::DCD_CMD_REF); // RULE14
        zql_d = (cmd == dcd_pkg::DCD_CMD_ZQCL); // RULE8
        odt_d = odt_i && (state_d != dcd_pkg::DCD_ST_SR) && (state_q != dcd_pkg::DCD_ST_SR); // RULE10
    end

    // transition periods only exist when the dll freezes in precharge power-down
    assign frozen = !mr0_q[dcd_pkg::MR0_DLL_PD];
    assign pd_entry = frozen && (cmd == dcd_pkg::DCD_CMD_PDE) && (open_q == '0);
    assign pd_exit = frozen && (cmd == dcd_pkg::DCD_CMD_PDX) && (open_q == '0);

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q <= dcd_pkg::DCD_ST_IDLE;
            open_q <= '0;
            mr0_q <= dcd_pkg::MR0_RST;
            cke_prev_q <= 1'b1;
            bcnt_q <= '0;
            req_o <= '0;
            req_vld_o <= 1'b0;
            refresh_o <= 1'b0;
            zq_long_o <= 1'b0;
            odt_en_o <= 1'b0;
            burst_busy_o <= 1'b0;
        end else if (clk_en_i) begin
            state_q <= state_d;
            open_q <= open_d;
            mr0_q <= mr0_d;
            cke_prev_q <= pins_i.cke;
            bcnt_q <= bcnt_d;
            req_o <= req_d;
            req_vld_o <= vld_d;
            refresh_o <= ref_d;
            zq_long_o <= zql_d;
            odt_en_o <= odt_d;
            burst_busy_o <= busy_d;
        end
    end
    assign state_o = state_q;
    assign bank_open_o = open_q;

    // window raised the cycle after the command and lengthened by 2*(wl-1) cycles, since its start lies before the cke edge
    dcd_odt_win #(
        .ENTRY_CYC(2 * (WL - 1) + CPDED_CYC),
        .EXIT_CYC(2 * (WL - 1) + XPDLL_CYC)
    ) u_win (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .entry_i(pd_entry),
        .exit_i(pd_exit),
        .win_o(odt_uncertain_o)
    );

    // ****************************************
    // assertions
    // ****************************************
    sequence s_col_issue;
        clk_en_i && col_cmd && bcnt_q == '0;
    endsequence
    sequence s_busy_two;
        burst_busy_o [*2];
    endsequence

    property p_mrs;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (clk_en_i && cmd == dcd_pkg::DCD_CMD_MRS) |=> (req_o.cmd == dcd_pkg::DCD_CMD_MRS) && req_vld_o;
    endproperty
    a_mrs: assert property (p_mrs) else $error("mode register set not reported"); // RULE5
    property p_srx;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (clk_en_i && state_q == dcd_pkg::DCD_ST_SR && pins_i.cke && pins_i.cs_n) |=> state_q == dcd_pkg::DCD_ST_IDLE;
    endproperty
    a_srx: assert property (p_srx) else $error("self refresh not left"); // RULE11
    property p_odt_sr;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state_q == dcd_pkg::DCD_ST_SR) ##1 (state_q == dcd_pkg::DCD_ST_SR) |-> !odt_en_o;
    endproperty
    a_odt_sr: assert property (p_odt_sr) else $error("termination on in self refresh"); // RULE10
    property p_no_ref_pd;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (clk_en_i && state_q == dcd_pkg::DCD_ST_PD) |=> !refresh_o;
    endproperty
    a_no_ref_pd: assert property (p_no_ref_pd) else $error("refresh during power-down"); // RULE14
    property p_burst;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        s_col_issue ##1 clk_en_i |-> s_busy_two;
    endproperty
    a_burst: assert property (p_burst) else $error("burst ended early"); // RULE13
    property p_nop_keep;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (clk_en_i && bcnt_q > 3'h1 && cmd == dcd_pkg::DCD_CMD_NOP) |=> burst_busy_o && bcnt_q == $past(bcnt_q) - 3'h1;
    endproperty
    a_nop_keep: assert property (p_nop_keep) else $error("nop disturbed a burst"); // RULE15
    property p_des;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (clk_en_i && pins_i.cs_n && pins_i.cke && cke_prev_q && !state_q[2] && !state_q[3])
            |=> req_o.cmd == dcd_pkg::DCD_CMD_DES && !req_vld_o;
    endproperty
    a_des: assert property (p_des) else $error("deselect not treated as idle"); // RULE16
    property p_ap;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (clk_en_i && col_cmd && pins_i.addr[dcd_pkg::A_AP]) |=> req_o.auto_pre && bank_open_o[req_o.bank] == 1'b0;
    endproperty
    a_ap: assert property (p_ap) else $error("auto precharge missed"); // RULE8
    property p_otf;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (clk_en_i && cmd == dcd_pkg::DCD_CMD_WR && mr0_q[dcd_pkg::MR0_BL_LSB+:2] == dcd_pkg::BL_OTF)
            |=> req_o.burst8 == $past(pins_i.addr[dcd_pkg::A_BC]);
    endproperty
    a_otf: assert property (p_otf) else $error("on-the-fly length wrong"); // RULE6
    property p_win;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (clk_en_i && (pd_entry || pd_exit)) ##1 clk_en_i |-> ##1 odt_uncertain_o;
    endproperty
    a_win: assert property (p_win) else $error("odt window not raised"); // RULE1 RULE2
endmodule

// file: tb_ddr3_command_decoder.sv
// self-checking testbench for the command decoder
`timescale 1ns/10ps
module tb_ddr3_command_decoder;
    // ****************************************
    // signals
    // ****************************************
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic odt_i = 1'b0;
    logic issue = 1'b0;
    logic armed = 1'b0;
    logic odt_prev = 1'b0;
    logic odt_live = 1'b0;
    dcd_pkg::dcd_state_t st_prev;
    logic [1:0] rz;
    dcd_pkg::dcd_pins_t cmd = '0;
    dcd_pkg::dcd_pins_t pins;
    dcd_pkg::dcd_req_t req_o;
    dcd_pkg::dcd_req_t head;
    dcd_pkg::dcd_state_t state_o;
    logic [7:0] bank_open_o;
    logic req_vld_o, burst_busy_o, refresh_o, zq_long_o, odt_en_o, odt_uncertain_o;
    int bad_count = 0;
    int comparisons = 0;
    int seed = 32'h66C1F6CF;
    int run_q = 0;
    int last_run = 0;
    int b;
    dcd_pkg::dcd_req_t exp_q[$];
    localparam logic [3:0] K_MRS = 4'h0, K_REF = 4'h1, K_PRE = 4'h2, K_ACT = 4'h3;
    localparam logic [3:0] K_WR = 4'h4, K_RD = 4'h5, K_ZQ = 4'h6, K_NOP = 4'h7, K_DES = 4'h8;
    always #5 clk_sys_i = ~clk_sys_i;
    dcd_ctrl_model u_dcd_ctrl_model (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .issue_i(issue),
        .cmd_i(cmd), .pins_o(pins));
    dcd_top u_dcd_top (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .pins_i(pins),
        .odt_i(odt_i), .req_o(req_o), .req_vld_o(req_vld_o), .state_o(state_o), .bank_open_o(bank_open_o),
        .burst_busy_o(burst_busy_o), .refresh_o(refresh_o), .zq_long_o(zq_long_o), .odt_en_o(odt_en_o),
        .odt_uncertain_o(odt_uncertain_o));
    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic send(input logic ck, input logic [3:0] k, input logic [2:0] ba, input logic [13:0] a,
        input dcd_pkg::dcd_cmd_t c, input logic b8);
        dcd_pkg::dcd_req_t e;
        @(posedge clk_sys_i);
        issue <= 1'b1;
        cmd <= {ck, k, ba, a};
        if (c != dcd_pkg::DCD_CMD_DES && c != dcd_pkg::DCD_CMD_RSVD) begin
            e.cmd = c;
            e.bank = ba;
            e.addr = a;
            e.auto_pre = a[10];
            e.burst8 = b8;
            exp_q.push_back(e);
        end
        @(posedge clk_sys_i);
        issue <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // watchers
    // ****************************************
    always @(posedge clk_sys_i) begin
        odt_i <= 1'($random(seed));
        odt_prev <= odt_i;
        st_prev <= state_o;
        odt_live <= !sys_rst_i && clk_en_i;
        // termination follows the request one cycle later outside self refresh
        if (odt_live && state_o != dcd_pkg::DCD_ST_SR && st_prev != dcd_pkg::DCD_ST_SR) begin
            check(32'(odt_en_o), 32'(odt_prev));
        end
        if (burst_busy_o === 1'b1) begin
            run_q <= run_q + 1;
        end else if (run_q != 0) begin
            last_run <= run_q;
            run_q <= 0;
        end
    end
    always @(posedge clk_sys_i) begin
        rz = 2'h0;
        if (armed && req_vld_o !== 1'b0) begin
            if (exp_q.size() == 0) begin
                check(32'(req_vld_o), 32'h0);
            end else begin
                head = exp_q.pop_front();
                rz = {head.cmd == dcd_pkg::DCD_CMD_REF, head.cmd == dcd_pkg::DCD_CMD_ZQCL};
                check(32'(req_o.cmd), 32'(head.cmd));
                if (head.cmd inside {dcd_pkg::DCD_CMD_RD, dcd_pkg::DCD_CMD_WR}) begin
                    check(32'(req_o.auto_pre), 32'(head.auto_pre));
                    check(32'(req_o.burst8), 32'(head.burst8));
                    check(32'(req_o.addr), 32'(head.addr));
                end
                if (head.cmd inside {dcd_pkg::DCD_CMD_MRS, dcd_pkg::DCD_CMD_ACT, dcd_pkg::DCD_CMD_PRE,
                    dcd_pkg::DCD_CMD_RD, dcd_pkg::DCD_CMD_WR}) begin
                    check(32'(req_o.bank), 32'(head.bank));
                end
                if (head.cmd == dcd_pkg::DCD_CMD_ACT) begin
                    check(32'(req_o.addr), 32'(head.addr));
                end
            end
        end
        if (armed) begin
            check(32'({refresh_o, zq_long_o}), 32'(rz));
        end
    end
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        bad_count++;
        results();
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (5) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        armed <= 1'b1;
        send(1'b1, K_MRS, 3'h0, 14'h0001, dcd_pkg::DCD_CMD_MRS, 1'b0);
        send(1'b1, K_ACT, 3'h3, 14'($random(seed)), dcd_pkg::DCD_CMD_ACT, 1'b0);
        send(1'b1, K_RD, 3'h3, 14'h1000, dcd_pkg::DCD_CMD_RD, 1'b1);
        send(1'b1, K_NOP, 3'h0, 14'h0000, dcd_pkg::DCD_CMD_NOP, 1'b0);
        idle(6);
        check(32'(last_run), 32'h4);
        send(1'b1, K_WR, 3'h3, 14'h0400, dcd_pkg::DCD_CMD_WR, 1'b0);
        idle(6);
        check(32'(last_run), 32'h2);
        check(32'(bank_open_o), 32'h0);
        for (int i = 0; i < 8; i++) begin
            send(1'b1, K_ACT, 3'(i), 14'($random(seed)), dcd_pkg::DCD_CMD_ACT, 1'b0);
        end
        idle(2);
        check(32'(bank_open_o), 32'hFF);
        b = $random(seed) & 7;
        send(1'b1, K_PRE, 3'(b), 14'($random(seed)) & 14'h3BFF, dcd_pkg::DCD_CMD_PRE, 1'b0);
        idle(2);
        check(32'(bank_open_o), 32'(8'hFF ^ (8'h01 << b)));
        send(1'b1, K_PRE, 3'h5, 14'h0400, dcd_pkg::DCD_CMD_PREA, 1'b0);
        idle(2);
        check(32'(bank_open_o), 32'h0);
        send(1'b1, K_REF, 3'h0, 14'h0000, dcd_pkg::DCD_CMD_REF, 1'b0);
        send(1'b1, K_ZQ, 3'h0, 14'h0400, dcd_pkg::DCD_CMD_ZQCL, 1'b0);
        send(1'b1, K_ZQ, 3'h0, 14'h0000, dcd_pkg::DCD_CMD_ZQCS, 1'b0);
        send(1'b0, K_NOP, 3'h0, 14'h0000, dcd_pkg::DCD_CMD_PDE, 1'b0);
        idle(2);
        check(32'(state_o), 32'(dcd_pkg::DCD_ST_PD));
        check(32'(odt_uncertain_o), 32'h1);
        send(1'b0, K_REF, 3'h0, 14'h0000, dcd_pkg::DCD_CMD_DES, 1'b0);
        send(1'b1, K_NOP, 3'h0, 14'h0000, dcd_pkg::DCD_CMD_PDX, 1'b0);
        send(1'b0, K_NOP, 3'h0, 14'h0000, dcd_pkg::DCD_CMD_PDE, 1'b0);
        idle(2);
        check(32'(odt_uncertain_o), 32'h1);
        send(1'b1, K_NOP, 3'h0, 14'h0000, dcd_pkg::DCD_CMD_PDX, 1'b0);
        idle(2);
        check(32'(state_o), 32'(dcd_pkg::DCD_ST_IDLE));
        idle(30);
        check(32'(odt_uncertain_o), 32'h0);
        // enable low: an activate on the pins must leave no trace
        @(posedge clk_sys_i);
        clk_en_i <= 1'b0;
        send(1'b1, K_ACT, 3'h6, 14'h0123, dcd_pkg::DCD_CMD_DES, 1'b0);
        idle(2);
        check(32'(bank_open_o), 32'h0);
        @(posedge clk_sys_i);
        clk_en_i <= 1'b1;
        send(1'b0, K_REF, 3'h0, 14'h0000, dcd_pkg::DCD_CMD_SRE, 1'b0);
        idle(2);
        check(32'(state_o), 32'(dcd_pkg::DCD_ST_SR));
        repeat (4) begin
            idle(1);
            check(32'(odt_en_o), 32'h0);
        end
        // no write follows self refresh exit in this run
        send(1'b1, K_DES, 3'h0, 14'h0000, dcd_pkg::DCD_CMD_SRX, 1'b0);
        idle(2);
        check(32'(state_o), 32'(dcd_pkg::DCD_ST_IDLE));
        send(1'b0, K_RD, 3'h0, 14'h0000, dcd_pkg::DCD_CMD_RSVD, 1'b0);
        idle(2);
        check(32'(state_o), 32'(dcd_pkg::DCD_ST_IDLE));
        send(1'b1, K_NOP, 3'h0, 14'h0000, dcd_pkg::DCD_CMD_DES, 1'b0);
        send(1'b1, K_NOP, 3'h0, 14'h0000, dcd_pkg::DCD_CMD_NOP, 1'b0);
        idle(4);
        check(32'(exp_q.size()), 32'h0);
        results();
    end
endmodule
